// ===== rtl/serial_eeprom_bus_slave.sv
// Purpose: two-wire serial EEPROM slave, 2K x 8, with page write and reads
// Assumes: SCL, SDA and WP are asynchronous pins, oversampled by CLK_SYS
// Notes:   storage is flip-flops; programming time is a shortenable parameter
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
module serial_eeprom_bus_slave
  import eeprom_pkg::*;
#(
  parameter int         PROG_CYCLES = PROG_CYCLES_DFLT,
  parameter logic [3:0] DEV_CODE    = DEV_CODE_DFLT   // arbitrary type code
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  // register bus
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // serial link
  input  wire logic        SCL,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  // write protect
  input  wire logic        WP
);

  eeprom_regs_if rif ();

  logic                    scl_s;
  logic                    sda_s;
  logic                    wp_s;
  logic                    scl_q;
  logic                    sda_q;
  link_state_t             state_q;
  logic [3:0]              bitcnt_q;
  logic [7:0]              shift_q;
  logic                    rw_q;
  logic [2:0]              blk_q;
  logic [ADDR_W-1:0]       addr_q;
  logic [ADDR_W-5:0]       pbase_q;
  logic [7:0]              pbuf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0]   pvalid_q;
  logic                    wr_ready_q;
  logic                    armed_q;
  logic                    cancel_q;
  logic                    wpc_seen_q;
  logic                    drive_low_q;
  logic                    mack_q;
  logic [PROG_W-1:0]       prog_cnt_q;
  logic [7:0]              mem_q [MEM_BYTES];

  // pins pass two flops before any logic sees them
  pin_sync #(.RST_VAL(1'b1)) u_scl (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .pin   (SCL),
    .sync  (scl_s)
  );
  pin_sync #(.RST_VAL(1'b1)) u_sda (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .pin   (SDA_IN),
    .sync  (sda_s)
  );
  pin_sync #(.RST_VAL(1'b1)) u_wp (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .pin   (WP),
    .sync  (wp_s)
  );

  // sub-word transfers are not decoded: every register is one whole word
  wire hsize_word = (HSIZE == 3'h2);

  eeprom_ahb_regs u_regs (
    .clk       (CLK_SYS),
    .rst_n     (RESET_N),
    .hsel      (HSEL && hsize_word),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .rif       (rif)
  );

  // edge and condition decode on the synchronised pins
  wire scl_rise   = scl_s && !scl_q;
  wire scl_fall   = !scl_s && scl_q;
  wire start_det  = scl_s && scl_q && sda_q && !sda_s;
  wire stop_det   = scl_s && scl_q && !sda_q && sda_s;
  wire busy       = (prog_cnt_q != '0);
  wire addr_match = (shift_q[7:4] == DEV_CODE) && rif.respond_en;
  wire byte_done  = (bitcnt_q == 4'd8);
  wire [7:0] rd_byte   = mem_q[addr_q];
  wire [7:0] wr_byte   = {shift_q[6:0], sda_s};
  // write commits only on a stop right after a whole byte, if not cancelled
  wire commit     = stop_det && wr_ready_q && !cancel_q;

  assign SDA_OUT          = 1'b0;           // open drain: only ever pulls low
  assign SDA_OE_N         = !drive_low_q;
  assign rif.busy         = busy;
  assign rif.wp_cancelled = wpc_seen_q;
  assign rif.cur_addr     = addr_q;

  // previous pin levels for edge detection
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // self-timed programming interval; bus is deaf while it runs
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      prog_cnt_q <= '0;
    end else if (commit) begin
      prog_cnt_q <= PROG_W'(PROG_CYCLES);  // one interval per page
    end else if (busy) begin
      prog_cnt_q <= prog_cnt_q - 1'b1;
    end
  end

  // cell array: the whole loaded page lands at once on commit
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_q[i] <= MEM_INIT;
      end
    end else if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pvalid_q[i]) begin
          mem_q[{pbase_q, 4'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

  // write-protect window: armed at the last bit of the first data byte
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cancel_q   <= 1'b0;
      wpc_seen_q <= 1'b0;
    end else begin
      if (start_det || stop_det) begin
        cancel_q <= 1'b0;
      end else if ((armed_q || (state_q == ST_WDATA && scl_rise && bitcnt_q == 4'd7))
                   && wp_s) begin
        cancel_q <= 1'b1;
      end
      // sticky until software disables the slave
      if (stop_det && wr_ready_q && cancel_q) begin
        wpc_seen_q <= 1'b1;
      end else if (!rif.respond_en) begin
        wpc_seen_q <= 1'b0;
      end
    end
  end

  // page buffer loading
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        pbuf_q[i] <= 8'h00;
      end
    end else if (state_q == ST_WDATA && scl_rise && bitcnt_q == 4'd7) begin
      pbuf_q[addr_q[3:0]] <= wr_byte;
    end
  end

  // protocol state machine
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q     <= ST_IDLE;
      bitcnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      rw_q        <= 1'b0;
      blk_q       <= 3'h0;
      addr_q      <= '0;
      pbase_q     <= '0;
      pvalid_q    <= '0;
      wr_ready_q  <= 1'b0;
      armed_q     <= 1'b0;
      drive_low_q <= 1'b0;
      mack_q      <= 1'b0;
    end else if (start_det) begin
      // a start (also a repeated one) restarts address reception, unless programming is busy: then it goes to ST_IDLE
      bitcnt_q    <= 4'h0;
      drive_low_q <= 1'b0;
      wr_ready_q  <= 1'b0;
      armed_q     <= 1'b0;
      state_q     <= busy ? ST_IDLE : ST_DEVADR;
    end else if (stop_det) begin
      // stop ends every command; start then stop aborts
      // addr_q keeps whatever it held, so a read abort leaves it stale
      state_q     <= ST_IDLE;
      drive_low_q <= 1'b0;
      wr_ready_q  <= 1'b0;
      armed_q     <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_WAIT_STOP: begin
          drive_low_q <= 1'b0;
        end
        ST_DEVADR: begin
          if (scl_rise) begin
            shift_q  <= wr_byte;
            bitcnt_q <= bitcnt_q + 4'd1;
          end else if (scl_fall && byte_done) begin
            if (addr_match) begin
              drive_low_q <= 1'b1;
              rw_q        <= shift_q[0];
              blk_q       <= shift_q[3:1];
              state_q     <= ST_ACK_DEV;
            end else begin
              state_q     <= ST_IDLE;
            end
          end
        end
        ST_ACK_DEV: begin
          if (scl_fall) begin
            bitcnt_q <= 4'h0;
            if (rw_q) begin
              // current read: internal address, then step it
              shift_q     <= rd_byte;
              drive_low_q <= !rd_byte[7];
              addr_q      <= addr_q + 1'b1;
              state_q     <= ST_RDATA;
            end else begin
              drive_low_q <= 1'b0;
              state_q     <= ST_WORDADR;
            end
          end
        end
        ST_WORDADR: begin
          if (scl_rise) begin
            shift_q  <= wr_byte;
            bitcnt_q <= bitcnt_q + 4'd1;
          end else if (scl_fall && byte_done) begin
            addr_q      <= {blk_q, shift_q};
            pbase_q     <= {blk_q, shift_q[7:4]};
            pvalid_q    <= '0;
            drive_low_q <= 1'b1;
            state_q     <= ST_ACK_WORD;
          end
        end
        ST_ACK_WORD, ST_ACK_DATA: begin
          if (scl_fall) begin
            drive_low_q <= 1'b0;
            bitcnt_q    <= 4'h0;
            state_q     <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            shift_q  <= wr_byte;
            bitcnt_q <= bitcnt_q + 4'd1;
            if (bitcnt_q == 4'd7) begin
              pvalid_q[addr_q[3:0]] <= 1'b1;
              addr_q[3:0] <= addr_q[3:0] + 4'd1; // wraps inside page
              wr_ready_q  <= 1'b1;
              armed_q     <= 1'b1;
            end
          end else if (scl_fall && byte_done) begin
            drive_low_q <= 1'b1;
            state_q     <= ST_ACK_DATA;
          end else if (scl_fall) begin
            // the stop's own scl rise looks like a first bit, so only a fall
            // proves that a further byte has really begun
            wr_ready_q  <= 1'b0;                 // partial byte blocks commit
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bitcnt_q <= bitcnt_q + 4'd1;
          end else if (scl_fall) begin
            if (byte_done) begin
              drive_low_q <= 1'b0;               // release for master ack
              state_q     <= ST_RACK;
            end else begin
              shift_q     <= {shift_q[6:0], 1'b0};
              drive_low_q <= !shift_q[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_q <= !sda_s;
          end else if (scl_fall) begin
            if (mack_q) begin
              // sequential read continues at the next address
              shift_q     <= rd_byte;
              drive_low_q <= !rd_byte[7];
              addr_q      <= addr_q + 1'b1;
              bitcnt_q    <= 4'h0;
              state_q     <= ST_RDATA;
            end else begin
              drive_low_q <= 1'b0;
              state_q     <= ST_WAIT_STOP;
            end
          end
        end
      endcase
    end
  end

endmodule : serial_eeprom_bus_slave

// ===== rtl/eeprom_pkg.sv
// Purpose: shared constants for the two-wire serial EEPROM slave
// Assumes: system clock of 25 MHz, 32-bit AHB-Lite register port
// Notes:   offsets are byte addresses of aligned words
package eeprom_pkg;

  // memory geometry
  localparam int          ADDR_W       = 11;
  localparam int          MEM_BYTES    = 2048;
  localparam int          PAGE_BYTES   = 16;
  localparam logic [7:0]  MEM_INIT     = 8'hFF;

  // device type code: arbitrary value, compared against the top address nibble
  localparam logic [3:0]  DEV_CODE_DFLT = 4'h5;

  // self-timed programming interval
  localparam int          PROG_TIME_US   = 5000;
  localparam int          CLK_FREQ_KHZ   = 25000;
  localparam int          PROG_CYCLES_DFLT = PROG_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int          PROG_W         = 24;

  // register map
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          ST_BUSY_BIT  = 0;
  localparam int          ST_WPC_BIT   = 1;
  localparam int          ST_ADDR_LSB  = 8;

  // serial protocol states
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEVADR, ST_ACK_DEV, ST_WORDADR, ST_ACK_WORD,
    ST_WDATA, ST_ACK_DATA, ST_RDATA, ST_RACK, ST_WAIT_STOP
  } link_state_t;

endpackage : eeprom_pkg

// ===== rtl/eeprom_regs_if.sv
// Purpose: carries control and status between the register slave and the core
// Assumes: both ends on CLK_SYS
// Notes:   no clocking block, plain modports
interface eeprom_regs_if;
  import eeprom_pkg::*;
  logic              respond_en;
  logic              busy;
  logic              wp_cancelled;
  logic [ADDR_W-1:0] cur_addr;
  modport core (input respond_en, output busy, output wp_cancelled, output cur_addr);
  modport regs (output respond_en, input busy, input wp_cancelled, input cur_addr);
endinterface : eeprom_regs_if

// ===== rtl/pin_sync.sv
// Purpose: two-stage synchroniser for one pin
// Assumes: input asynchronous to clk
// Notes:   RST_VAL chosen to match the idle bus level
module pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin and result
  input  wire logic pin,
  output logic      sync
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync   <= RST_VAL;
    end else begin
      meta_q <= pin;
      sync   <= meta_q;
    end
  end
endmodule : pin_sync

// ===== rtl/eeprom_ahb_regs.sv
// Purpose: AHB-Lite slave holding control and status words
// Assumes: single word transfers, zero wait states
// Notes:   unmapped reads return zero, writes there are dropped
module eeprom_ahb_regs
  import eeprom_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // core side
  eeprom_regs_if.regs      rif
);
  logic        wr_pend_q;
  logic [11:0] wr_ofs_q;
  logic        en_q;

  // address phase decode
  wire         take     = hsel && htrans[1] && hready;
  wire  [11:0] ofs      = haddr[11:0];
  wire  [31:0] status_w = {{(32-ST_ADDR_LSB-ADDR_W){1'b0}}, rif.cur_addr,
                           {(ST_ADDR_LSB-2){1'b0}}, rif.wp_cancelled, rif.busy};
  wire  [31:0] rd_mux   = (ofs == CTRL_OFS)   ? {31'h0, en_q} :
                          (ofs == STATUS_OFS) ? status_w : 32'h0;

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign rif.respond_en = en_q;

  // read data captured at the address phase so it stands in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata    <= 32'h0;
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 12'h000;
    end else begin
      hrdata    <= (take && !hwrite) ? rd_mux : 32'h0;
      wr_pend_q <= take && hwrite;
      wr_ofs_q  <= ofs;
    end
  end

  // write lands in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= CTRL_EN_RST;
    end else if (wr_pend_q && wr_ofs_q == CTRL_OFS) begin
      en_q <= hwdata[CTRL_EN_BIT];
    end
  end
endmodule : eeprom_ahb_regs

// ===== verif/eeprom_properties.sv
// Purpose: pin-level checks of the EEPROM slave
// Assumes: SCL low phase of five system clocks or more
// Notes:   sda change window counted from the raw SCL fall
module eeprom_properties (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET_N,
  // register bus
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // serial link
  input wire logic        SCL,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  logic       scl_q;
  logic [3:0] age_q;
  logic [3:0] age_d;
  wire        rd_go = HSEL & HTRANS[1] & HREADY & ~HWRITE;
  // saturate so a long high phase never wraps back into the window
  assign age_d = (scl_q & ~SCL) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_q <= 1'b1;
      age_q <= 4'hF;
    end else begin
      scl_q <= SCL;
      age_q <= age_d;
    end
  end
  // bus answers and the open-drain pin
  property p_ready; HREADYOUT == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen"); // zero wait
  property p_okay; HRESP == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen"); // okay only
  property p_drain; SDA_OUT == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("sda driven high");
  property p_rd_idle; !$past(rd_go) |-> HRDATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside phase"); // idle zero
  // sda only moves while scl is low, so the slave never fakes a condition
  property p_drive; $fell(SDA_OE_N) |-> !SCL; endproperty
  a_drive: assert property (p_drive) else $error("sda pulled in scl high");
  property p_release; $rose(SDA_OE_N) |-> !SCL; endproperty
  a_release: assert property (p_release) else $error("sda freed in scl high");
  property p_window; $changed(SDA_OE_N) |-> age_q <= 4'h4; endproperty
  a_window: assert property (p_window) else $error("sda change late");
  property p_hold; $fell(SDA_OE_N) |=> !SDA_OE_N [*3]; endproperty
  a_hold: assert property (p_hold) else $error("low bit too short");
endmodule : eeprom_properties

bind serial_eeprom_bus_slave eeprom_properties chk (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N));

// ===== verif/i2c_master_model.sv
// Purpose: behavioural two-wire bus master, SCL and open-drain SDA
// Assumes: tasks entered just after a clock rising edge
// Notes:   scl low five cycles, high three, 320 ns a bit
module i2c_master_model (
  // clock
  input  wire logic clk,
  // bus
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one clock period; data moves only while scl is low
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    @(posedge clk);
    sda_low <= ~b;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    s = sda;
  endtask : bit_io
  // works from idle and as a repeated start
  task automatic start();
    scl <= 1'b0;
    repeat (3) @(posedge clk);
    sda_low <= 1'b0;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_low <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : start
  task automatic stop();
    scl <= 1'b0;
    @(posedge clk);
    sda_low <= 1'b1;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_low <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s); // let go for the ninth clock
    ack = ~s; // an unknown line stays unknown and fails the compare
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, s); // low asks for more, high ends the read
  endtask : rbyte
  // released, not driven high: the slave may still hold sda low
  task automatic dummy(input int n);
    logic s;
    repeat (n) bit_io(1'b1, s);
  endtask : dummy
endmodule : i2c_master_model

// ===== verif/tb.sv
// Purpose: self-checking bench for the EEPROM slave and its registers
// Assumes: programming shortened to PROG system clocks
// Notes:   sda is a pulled-up wire resolved from both open-drain sides
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_pkg::*;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
  localparam int PROG = 200;
  logic        clk_sys, reset_n, hsel, hwrite, wp, ack;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, sda_out, sda_oe_n, scl, m_low;
  logic [7:0]  b;
  logic [7:0]  exp_seq [4] = '{8'h4F, 8'h50, 8'h41, 8'hFF};
  wire         sda;
  int          mismatches = 0;
  int          total_checks = 0;
  int          n;
  // low when either side pulls, otherwise the pull-up
  assign sda = ~(m_low | (~sda_oe_n & ~sda_out));
  serial_eeprom_bus_slave #(.PROG_CYCLES(PROG)) uut (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .WP(wp));
  i2c_master_model m (.clk(clk_sys), .scl(scl), .sda_low(m_low), .sda(sda));
  // 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  function automatic logic [7:0] sa(input logic [2:0] blk, input logic rw);
    return {DEV_CODE_DFLT, blk, rw};
  endfunction : sa
  task automatic addr_cmd(input logic [7:0] a);
    m.start();
    m.wbyte(a, ack);
  endtask : addr_cmd
  // leaves the slave ready to send from {blk, wa}
  task automatic rd_at(input logic [2:0] blk, input logic [7:0] wa);
    addr_cmd(sa(blk, 1'b0));
    m.wbyte(wa, ack);
    addr_cmd(sa(blk, 1'b1));
  endtask : rd_at
  // repeat the address until it is answered
  task automatic poll();
    n = 0;
    do begin
      addr_cmd(sa(3'h0, 1'b0));
      n++;
    end while (ack !== 1'b1 && n < 40);
    m.stop();
  endtask : poll
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // a hang counts as a failure
  initial begin
    #2_000_000;
    mismatches++;
    summarize();
  end
  // main sequence
  initial begin
    {reset_n, hsel, hwrite, wp, htrans, haddr, hwdata} = '0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ahb(1'b0, CTRL_OFS, 32'h0, rd);
    `CHK(rd[CTRL_EN_BIT], CTRL_EN_RST)
    ahb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK(rd[ST_WPC_BIT:ST_BUSY_BIT], 2'b00)
    ahb(1'b0, 12'h008, 32'h0, rd);
    `CHK(rd, 32'h0)
    addr_cmd(8'h3A);
    m.stop();
    `CHK(ack, 1'b0)
    $display("test registers and type code done");
    addr_cmd(sa(3'h3, 1'b0));
    `CHK(ack, 1'b1)
    m.wbyte(8'h0E, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < 17; i++) begin
      m.wbyte(8'(8'h40 + i), ack);
      `CHK(ack, 1'b1)
    end
    m.stop();
    ahb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK(rd[ST_BUSY_BIT], 1'b1)
    poll();
    `CHK(n > 1, 1'b1)
    `CHK(ack, 1'b1)
    rd_at(3'h3, 8'h00);
    m.rbyte(1'b0, b);
    m.stop();
    `CHK(b, 8'h42)
    addr_cmd(sa(3'h3, 1'b1));
    m.rbyte(1'b0, b);
    m.stop();
    `CHK(b, 8'h43)
    ahb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK(rd[ST_ADDR_LSB +: ADDR_W], 11'h302)
    rd_at(3'h3, 8'h0D);
    for (int i = 0; i < 4; i++) begin
      m.rbyte(i < 3, b);
      `CHK(b, exp_seq[i])
    end
    m.stop();
    rd_at(3'h2, 8'h00);
    `CHK(ack, 1'b1)
    m.rbyte(1'b0, b);
    m.stop();
    `CHK(b, MEM_INIT)
    $display("test page write and reads done");
    wp <= 1'b1;
    addr_cmd(sa(3'h1, 1'b0));
    m.wbyte(8'h06, ack);
    wp <= 1'b0;
    m.wbyte(8'h66, ack);
    m.stop();
    ahb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK(rd[ST_BUSY_BIT], 1'b1)
    poll();
    wp <= 1'b1;
    addr_cmd(sa(3'h1, 1'b0));
    m.wbyte(8'h05, ack);
    m.wbyte(8'h12, ack);
    m.stop();
    wp <= 1'b0;
    ahb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK(rd[ST_WPC_BIT:ST_BUSY_BIT], 2'b10)
    rd_at(3'h1, 8'h05);
    `CHK(ack, 1'b1)
    m.rbyte(1'b1, b);
    `CHK(b, MEM_INIT)
    m.rbyte(1'b0, b);
    m.stop();
    `CHK(b, 8'h66)
    $display("test write protect done");
    ahb(1'b1, CTRL_OFS, 32'h0, rd);
    ahb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK(rd[ST_WPC_BIT], 1'b0)
    addr_cmd(sa(3'h1, 1'b0));
    m.stop();
    `CHK(ack, 1'b0)
    ahb(1'b1, CTRL_OFS, 32'h1, rd);
    addr_cmd(sa(3'h1, 1'b0));
    m.wbyte(8'h07, ack);
    m.start();
    m.stop();
    poll();
    `CHK(n, 1)
    m.start();
    m.dummy(9);
    poll();
    `CHK(n, 1)
    m.dummy(14);
    m.start();
    poll();
    `CHK(n, 1)
    $display("test enable, abort and resets done");
    summarize();
  end
endmodule : tb
